// ==== coepu_pkg.sv ====
// Constants for the compare output enhanced PWM unit
package coepu_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_MODE  = 4'h1;
    localparam logic [3:0] ADDR_FORCE = 4'h2;
    localparam logic [3:0] ADDR_HIGH  = 4'h3;
    localparam logic [3:0] ADDR_CMPA  = 4'h4;
    localparam logic [3:0] ADDR_CMPB  = 4'h5;
    localparam logic [3:0] ADDR_CMPD  = 4'h6;
    localparam logic [3:0] ADDR_TOP   = 4'h7;
    localparam logic [3:0] ADDR_DEAD  = 4'h8;
    localparam logic [3:0] ADDR_STAT  = 4'h9;

    // Bit positions in control_register_e
    localparam int CTRL_PWM  = 0;
    localparam int CTRL_ENH  = 1;
    localparam int CTRL_LOCK = 2;

    // Field positions in the dead-time register
    localparam int DEAD_RISE_LSB = 0;
    localparam int DEAD_FALL_LSB = 4;

    // Encodings of output_mode_field
    localparam logic [1:0] OM_NONE   = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;

    // Reset values
    localparam logic [10:0] CMP_RST  = 11'h000;
    localparam logic [9:0]  TOP_RST  = 10'h000;
    localparam logic [3:0]  DEAD_RST = 4'h0;

    // Number of compare channels with accuracy bit (A, B, D)
    localparam int CH_N = 3;

endpackage

// ==== coepu_unit.sv ====
// Compare output stage with enhanced accuracy bit, dead time and update lock
module coepu_unit (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Timer counter side
    input  wire logic [9:0]  counter_value,
    input  wire logic        timer_tick,
    input  wire logic        cycle_end,
    output logic      [9:0]  period_top_value,
    // Port logic side
    input  wire logic [2:0]  port_value,
    input  wire logic [2:0]  port_value_n,
    input  wire logic [5:0]  pin_direction_bit,
    // Pin pairs
    output logic      [2:0]  pin_true_o,
    output logic      [2:0]  pin_true_oe,
    output logic      [2:0]  pin_comp_o,
    output logic      [2:0]  pin_comp_oe,
    // Observed state
    output logic      [2:0]  compare_output_signal,
    output logic      [2:0]  waveform_output
);

    typedef struct packed {
        logic             pwm;
        logic             enh;
        logic             lock;
        logic [2:0][1:0]  omode;
        logic [2:0]       high;
        logic [2:0][10:0] buf_v;
        logic [2:0][10:0] act_v;
        logic [9:0]       top_buf;
        logic [9:0]       top_act;
        logic [3:0]       dt_rise;
        logic [3:0]       dt_fall;
        logic [2:0]       wave;
        logic [2:0]       wave_d;
        logic [2:0]       half;
        logic [2:0][3:0]  dt_cnt;
        logic [2:0]       oc;
        logic [2:0]       oc_n;
        logic [7:0]       rdata;
        logic [2:0]       pin_t;
        logic [2:0]       pin_t_oe;
        logic [2:0]       pin_c;
        logic [2:0]       pin_c_oe;
    } coepu_state_t;

    coepu_state_t state_ff;
    coepu_state_t nxt_state;

    always_comb begin
        logic [9:0] cmpv;
        logic       hit;
        logic       frc;
        logic       fire;
        logic       compl;
        logic [3:0] dtv;
        logic [1:0] ch;
        cmpv  = 10'h000;
        hit   = 1'b0;
        frc   = 1'b0;
        fire  = 1'b0;
        compl = 1'b0;
        dtv   = 4'h0;
        ch    = reg_addr[1:0];
        nxt_state = state_ff;
        nxt_state.rdata = 8'h00;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                coepu_pkg::ADDR_CTRL: begin
                    nxt_state.pwm  = reg_wdata[coepu_pkg::CTRL_PWM];
                    nxt_state.enh  = reg_wdata[coepu_pkg::CTRL_ENH];
                    nxt_state.lock = reg_wdata[coepu_pkg::CTRL_LOCK];
                end
                coepu_pkg::ADDR_MODE: begin
                    nxt_state.omode = reg_wdata[5:0];
                end
                coepu_pkg::ADDR_HIGH: begin
                    nxt_state.high = reg_wdata[2:0];
                end
                coepu_pkg::ADDR_CMPA, coepu_pkg::ADDR_CMPB, coepu_pkg::ADDR_CMPD: begin
                    // Buffer overwritten each time, last write wins under lock
                    if (state_ff.enh)
                        nxt_state.buf_v[ch] = {state_ff.high, reg_wdata};
                    else
                        nxt_state.buf_v[ch] = {1'b0, state_ff.high[1:0], reg_wdata};
                end
                coepu_pkg::ADDR_TOP: begin
                    // Period never carries the accuracy bit
                    nxt_state.top_buf = {state_ff.high[1:0], reg_wdata};
                end
                coepu_pkg::ADDR_DEAD: begin
                    nxt_state.dt_rise = reg_wdata[coepu_pkg::DEAD_RISE_LSB +: 4];
                    nxt_state.dt_fall = reg_wdata[coepu_pkg::DEAD_FALL_LSB +: 4];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data stand in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                coepu_pkg::ADDR_CTRL: begin
                    nxt_state.rdata = {5'h00, state_ff.lock, state_ff.enh, state_ff.pwm};
                end
                coepu_pkg::ADDR_MODE: begin
                    nxt_state.rdata = {2'h0, state_ff.omode};
                end
                coepu_pkg::ADDR_HIGH: begin
                    nxt_state.rdata = {5'h00, state_ff.high};
                end
                coepu_pkg::ADDR_CMPA, coepu_pkg::ADDR_CMPB, coepu_pkg::ADDR_CMPD: begin
                    // Most recent written value; high part lands in the temp
                    nxt_state.rdata = state_ff.buf_v[ch][7:0];
                    nxt_state.high  = state_ff.buf_v[ch][10:8];
                end
                coepu_pkg::ADDR_TOP: begin
                    nxt_state.rdata = state_ff.top_buf[7:0];
                    nxt_state.high  = {1'b0, state_ff.top_buf[9:8]};
                end
                coepu_pkg::ADDR_DEAD: begin
                    nxt_state.rdata = {state_ff.dt_fall, state_ff.dt_rise};
                end
                coepu_pkg::ADDR_STAT: begin
                    nxt_state.rdata = {2'h0, state_ff.wave, state_ff.oc};
                end
                default: begin
                    nxt_state.rdata = 8'h00;
                end
            endcase
        end

        // Buffered values reach the comparators together at cycle end
        // In normal mode double buffering is off, so transfer is immediate
        if (!state_ff.lock && (!state_ff.pwm || cycle_end)) begin
            nxt_state.act_v   = state_ff.buf_v;
            nxt_state.top_act = state_ff.top_buf;
        end

        for (int i = 0; i < coepu_pkg::CH_N; i++) begin
            // Comparator, enhanced mode drops the accuracy bit off the value
            cmpv = state_ff.enh ? state_ff.act_v[i][10:1] : state_ff.act_v[i][9:0];
            hit  = timer_tick && (counter_value == cmpv);
            // Force touches only the waveform: no flag, no counter effect
            frc  = reg_wr && (reg_addr == coepu_pkg::ADDR_FORCE) && reg_wdata[i]
                   && !state_ff.pwm;
            // Accuracy bit 1 moves the match to the following half step
            nxt_state.half[i] = hit && state_ff.enh && state_ff.act_v[i][0];
            fire = frc || state_ff.half[i]
                   || (hit && !(state_ff.enh && state_ff.act_v[i][0]));

            // Waveform generator, mode read at the match itself
            if (state_ff.pwm && cycle_end && state_ff.omode[i] != coepu_pkg::OM_NONE)
                nxt_state.wave[i] = (state_ff.omode[i] != coepu_pkg::OM_SET);
            if (fire) begin
                case (state_ff.omode[i])
                    coepu_pkg::OM_TOGGLE: nxt_state.wave[i] = state_ff.pwm ? 1'b0
                                                              : ~state_ff.wave[i];
                    coepu_pkg::OM_CLEAR:  nxt_state.wave[i] = 1'b0;
                    coepu_pkg::OM_SET:    nxt_state.wave[i] = 1'b1;
                    default: begin
                        nxt_state.wave[i] = state_ff.wave[i];
                    end
                endcase
            end

            // Dead-time stage
            compl = state_ff.pwm && (state_ff.omode[i] == coepu_pkg::OM_TOGGLE);
            dtv   = state_ff.wave[i] ? state_ff.dt_rise : state_ff.dt_fall;
            nxt_state.wave_d[i] = state_ff.wave[i];
            if (compl) begin
                if (state_ff.wave[i] != state_ff.wave_d[i] && dtv != 4'h0) begin
                    // Both sides low while the gap runs
                    nxt_state.oc[i]     = 1'b0;
                    nxt_state.oc_n[i]   = 1'b0;
                    nxt_state.dt_cnt[i] = dtv - 4'h1;
                end else if (state_ff.wave[i] != state_ff.wave_d[i]) begin
                    nxt_state.oc[i]   = state_ff.wave[i];
                    nxt_state.oc_n[i] = ~state_ff.wave[i];
                end else if (state_ff.dt_cnt[i] != 4'h0) begin
                    nxt_state.dt_cnt[i] = state_ff.dt_cnt[i] - 4'h1;
                end else begin
                    nxt_state.oc[i]   = state_ff.wave_d[i];
                    nxt_state.oc_n[i] = ~state_ff.wave_d[i];
                end
            end else begin
                // Plain synchroniser, one clock behind the waveform
                nxt_state.oc[i]     = state_ff.wave[i];
                nxt_state.oc_n[i]   = ~state_ff.wave[i];
                nxt_state.dt_cnt[i] = 4'h0;
            end

            // Pin override; direction stays with the port logic
            nxt_state.pin_t[i] = (state_ff.omode[i] != coepu_pkg::OM_NONE)
                                 ? state_ff.oc[i] : port_value[i];
            nxt_state.pin_c[i] = compl ? state_ff.oc_n[i] : port_value_n[i];
            // State evolves even with direction set to input
            nxt_state.pin_t_oe[i] = pin_direction_bit[i];
            nxt_state.pin_c_oe[i] = pin_direction_bit[i + 3];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata             = state_ff.rdata;
    assign period_top_value      = state_ff.top_act;
    assign pin_true_o            = state_ff.pin_t;
    assign pin_true_oe           = state_ff.pin_t_oe;
    assign pin_comp_o            = state_ff.pin_c;
    assign pin_comp_oe           = state_ff.pin_c_oe;
    assign compare_output_signal = state_ff.oc;
    assign waveform_output       = state_ff.wave;

endmodule // coepu_unit

// ==== coepu_props.sv ====
// Port checker for the compare output unit
module coepu_props (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       clk_en,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Timer side
    input wire logic       timer_tick,
    input wire logic       cycle_end,
    input wire logic [9:0] period_top_value,
    // Port and pins
    input wire logic [2:0] port_value,
    input wire logic [5:0] pin_direction_bit,
    input wire logic [2:0] pin_true_o,
    input wire logic [2:0] pin_true_oe,
    input wire logic [2:0] pin_comp_oe,
    input wire logic [2:0] compare_output_signal,
    input wire logic [2:0] waveform_output
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_release;
        $fell(rst);
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == coepu_pkg::ADDR_STAT;
    endsequence
    property p_rst_clear;
        s_release |-> compare_output_signal == 3'h0 && waveform_output == 3'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("state not clear after reset");
    property p_stat;
        s_stat_rd |=> reg_rdata == {2'h0, $past(waveform_output), $past(compare_output_signal)};
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_rd_idle;
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_oe_true;
        $past(clk_en) |-> pin_true_oe == $past(pin_direction_bit[2:0]);
    endproperty
    a_oe_true: assert property (p_oe_true) else $error("true pin enable wrong");
    property p_oe_comp;
        $past(clk_en) |-> pin_comp_oe == $past(pin_direction_bit[5:3]);
    endproperty
    a_oe_comp: assert property (p_oe_comp) else $error("comp pin enable wrong");
    property p_pin_src;
        $past(clk_en) |-> ((pin_true_o ^ $past(port_value))
            & (pin_true_o ^ $past(compare_output_signal))) == 3'h0;
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("true pin source wrong");
    property p_oc_sync;
        (compare_output_signal & ~$past(compare_output_signal) & ~$past(waveform_output)) == 3'h0;
    endproperty
    a_oc_sync: assert property (p_oc_sync) else $error("output rose ahead of wave");
    property p_wave_cause;
        $changed(waveform_output) |-> $past(timer_tick) || $past(timer_tick, 2)
            || $past(cycle_end) || $past(reg_wr);
    endproperty
    a_wave_cause: assert property (p_wave_cause) else $error("wave moved alone");
    property p_top_upd;
        $changed(period_top_value) |-> $past(reg_wr) || $past(reg_wr, 2)
            || $past(cycle_end) || $past(cycle_end, 2);
    endproperty
    a_top_upd: assert property (p_top_upd) else $error("period moved alone");
endmodule // coepu_props

bind coepu_unit coepu_props u_props (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .timer_tick, .cycle_end, .period_top_value, .port_value, .pin_direction_bit,
    .pin_true_o, .pin_true_oe, .pin_comp_oe, .compare_output_signal, .waveform_output);

// ==== coepu_pads.sv ====
// Port pin model: pad level from the drive enables
module coepu_pads (
    // Clock
    input wire logic       sys_clk,
    // Pin drive
    input wire logic [2:0] pin_true_o,
    input wire logic [2:0] pin_true_oe,
    input wire logic [2:0] pin_comp_o,
    input wire logic [2:0] pin_comp_oe,
    // Pad levels
    output logic     [2:0] pad_true,
    output logic     [2:0] pad_comp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] float_ff = 3'h5;
    // Undriven pads wander so a stale level never passes for a drive
    always @(posedge sys_clk) float_ff <= ~float_ff;
    assign pad_true = (pin_true_oe & pin_true_o) | (~pin_true_oe & float_ff);
    assign pad_comp = (pin_comp_oe & pin_comp_o) | (~pin_comp_oe & float_ff);
endmodule // coepu_pads

// ==== tb.sv ====
// Self-checking bench for the compare output unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rst, clk_en, reg_wr, reg_rd, timer_tick, cycle_end;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rv;
    logic [9:0]  counter_value, period_top_value;
    logic [2:0]  port_value, port_value_n, pin_true_o, pin_true_oe, pin_comp_o, pin_comp_oe;
    logic [2:0]  compare_output_signal, waveform_output, pad_true, pad_comp, mw;
    logic [5:0]  pin_direction_bit;
    logic [10:0] v;
    int          err_total, checks, q[$];
    int unsigned seed;
    coepu_unit uut (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .counter_value, .timer_tick, .cycle_end, .period_top_value, .port_value,
        .port_value_n, .pin_direction_bit, .pin_true_o, .pin_true_oe, .pin_comp_o,
        .pin_comp_oe, .compare_output_signal, .waveform_output);
    coepu_pads u_pads (.sys_clk, .pin_true_o, .pin_true_oe, .pin_comp_o, .pin_comp_oe,
        .pad_true, .pad_comp);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #2000000;
        err_total++;
        test_done();
    end
    task test_done();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [10:0] g, input logic [10:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Non-PWM action at a match or a force
    function automatic logic nxt(input logic [1:0] m, input logic w);
        return (m == 2'h1) ? ~w : (m == 2'h0) ? w : m[0];
    endfunction
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // High bits first; the low byte write latches the whole value
    task wv(input logic [3:0] a, input logic [10:0] x);
        wr(coepu_pkg::ADDR_HIGH, {5'h00, x[10:8]});
        wr(a, x[7:0]);
        @(posedge sys_clk);
    endtask
    task step(input logic [9:0] c, input logic t, input logic e);
        @(posedge sys_clk);
        counter_value <= c;
        timer_tick <= t;
        cycle_end <= e;
        @(posedge sys_clk);
        {timer_tick, cycle_end} <= 2'b00;
    endtask
    initial begin
        {rst, clk_en, reg_wr, reg_rd, timer_tick, cycle_end} = 6'h30;
        {reg_addr, reg_wdata, counter_value, pin_direction_bit, mw} = '0;
        seed = $urandom(68056);
        {port_value, port_value_n} = 6'($urandom);
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd(coepu_pkg::ADDR_STAT, rv);
        cmp(rv, 11'h000);
        rd(4'hF, rv);
        cmp(rv, 11'h000);
        for (int m = 0; m < 4; m++) begin
            wr(coepu_pkg::ADDR_MODE, 8'(m));
            wr(coepu_pkg::ADDR_FORCE, 8'h01);
            mw[0] = nxt(2'(m), mw[0]);
            @(negedge sys_clk);
            cmp(waveform_output, mw);
        end
        // A force taken while the clock enable is low must leave the waveform frozen
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(coepu_pkg::ADDR_FORCE, 8'h01);
        @(negedge sys_clk);
        cmp(waveform_output, mw);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        wr(coepu_pkg::ADDR_MODE, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(coepu_pkg::ADDR_CTRL, (i > 2) ? 8'h02 : 8'h00);
            v = 11'($urandom);
            v[10] = v[10] & (i > 2);
            v[0] = (i > 2) ? i[0] : v[0];
            wv(coepu_pkg::ADDR_CMPA, v);
            step((i > 2) ? v[10:1] : v[9:0], 1'b1, 1'b0);
            @(negedge sys_clk);
            cmp(waveform_output[0], mw[0] ^ !(i > 2 && v[0]));
            @(negedge sys_clk);
            mw[0] = ~mw[0];
            cmp(waveform_output[0], mw[0]);
        end
        wv(coepu_pkg::ADDR_TOP, 11'h7AB);
        repeat (3) @(negedge sys_clk);
        cmp(period_top_value, 11'h3AB);
        rd(coepu_pkg::ADDR_TOP, rv);
        cmp(rv, 11'h0AB);
        rd(coepu_pkg::ADDR_HIGH, rv);
        cmp(rv, 11'h003);
        wr(coepu_pkg::ADDR_CTRL, 8'h00);
        wv(coepu_pkg::ADDR_CMPA, 11'h000);
        wr(coepu_pkg::ADDR_CTRL, 8'h04);
        repeat (2) begin
            q.push_back(1 + $urandom % 1023);
            wv(coepu_pkg::ADDR_CMPA, 11'(q[$]));
        end
        step(10'h000, 1'b0, 1'b1);
        step(10'(q[$]), 1'b1, 1'b0);
        @(negedge sys_clk);
        cmp(waveform_output, mw);
        wr(coepu_pkg::ADDR_CTRL, 8'h00);
        step(10'(q[$]), 1'b0, 1'b1);
        step(10'(q[$]), 1'b1, 1'b0);
        @(negedge sys_clk);
        mw[0] = ~mw[0];
        cmp(waveform_output, mw);
        @(posedge sys_clk);
        pin_direction_bit <= 6'h09;
        wr(coepu_pkg::ADDR_DEAD, 8'h00);
        wr(coepu_pkg::ADDR_CTRL, 8'h01);
        wr(coepu_pkg::ADDR_FORCE, 8'h01);
        @(negedge sys_clk);
        cmp(waveform_output, mw);
        step(10'(q[$]), 1'b0, 1'b1);
        repeat (4) @(negedge sys_clk);
        cmp({pad_true[0], pad_comp[0]}, 11'h002);
        step(10'(q[$]), 1'b1, 1'b0);
        repeat (4) @(negedge sys_clk);
        cmp({pad_true[0], pad_comp[0]}, 11'h001);
        wr(coepu_pkg::ADDR_DEAD, 8'h03);
        step(10'(q[$]), 1'b0, 1'b1);
        repeat (2) @(negedge sys_clk);
        cmp(compare_output_signal[0], 1'b0);
        repeat (4) @(negedge sys_clk);
        cmp(compare_output_signal[0], 1'b1);
        wr(coepu_pkg::ADDR_MODE, 8'h02);
        repeat (3) @(negedge sys_clk);
        cmp(pad_comp[0], port_value_n[0]);
        wr(coepu_pkg::ADDR_MODE, 8'h00);
        repeat (3) @(negedge sys_clk);
        cmp(pad_true[0], port_value[0]);
        test_done();
    end
endmodule // tb
